// [include/rbh_defines.svh]
/*
 Constants for the reset and boot handshake controller: register offsets,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef RBH_DEFINES_SVH
`define RBH_DEFINES_SVH

// Register byte offsets on the AHB-Lite slave.
`define RBH_OFS_CTRL 8'h00
`define RBH_OFS_STATUS 8'h04
`define RBH_OFS_INT_CLR 8'h08
`define RBH_OFS_INT_EN 8'h0C
`define RBH_OFS_SOFTRST 8'h10
`define RBH_OFS_BOOT 8'h14
`define RBH_OFS_CAUSE 8'h18

// Control register fields.
`define RBH_CTRL_DBG_MSK 0
`define RBH_CTRL_WATCHDOG_RESET_MASK 1
`define RBH_CTRL_PLL_UNLOCK_MASK 2
`define RBH_CTRL_WKUP_ENA 3
`define RBH_CTRL_WDT_ENA 4
`define RBH_CTRL_VECT_SEL 5
`define RBH_CTRL_WIDTH 6
`define RBH_CTRL_RESET 6'h00

// Boot register fields.
`define RBH_BOOT_READY 0
`define RBH_BOOT_DONE 1

// Interrupt status fields.
`define RBH_INT_BOOT_READY 0
`define RBH_INT_BOOT_DONE 1
`define RBH_INT_WARM 2
`define RBH_INT_WIDTH 3

// Software reset fields reset to held (zero).
`define RBH_SOFTRST_RESET 8'h00

// Minimum warm reset pulse in ns and derived cycles at 4 ns.
`define RBH_WARM_MIN_NS 64
`define RBH_CLK_NS 4
`define RBH_WARM_CYCLES ((`RBH_WARM_MIN_NS + `RBH_CLK_NS - 1) / `RBH_CLK_NS)

`endif

// [include/rbh_pkg.sv]
/*
 Types for the reset and boot handshake controller.
 Assumes the defines header is on the include path.
*/
package rbh_pkg;
  // Boot sequencer states, one-hot.
  typedef enum logic [3:0] {
    RBH_ST_HELD = 4'h1,
    RBH_ST_SELFTEST = 4'h2,
    RBH_ST_READY = 4'h4,
    RBH_ST_RUN = 4'h8
  } rbh_boot_t;
endpackage

// [verilog/rbh_sync3.sv]
/*
 Three-stage pin synchroniser: the output changes once stages two and three
 agree. Assumes the clock domain of the importer.
*/
`timescale 1ns/10ps
module rbh_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and control.
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Pin in, filtered level out.
  input wire logic pin_i,
  output logic level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Shift chain; only stage two reads stage one.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end else if (ce_i) begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a new level only when the last two stages agree.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      level_o <= RESET_VAL;
    end else if (ce_i && (s2_reg == s3_reg)) begin
      level_o <= s3_reg;
    end
  end
endmodule

// [verilog/rbh_warm_stretch.sv]
/*
 Holds the warm reset asserted for at least a fixed number of cycles after
 the last trigger. Assumes a synchronous, same-domain request.
*/
`timescale 1ns/10ps
`include "rbh_defines.svh"
module rbh_warm_stretch #(
  parameter int CYCLES = `RBH_WARM_CYCLES
) (
  // Clock and control.
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Request in, stretched reset out.
  input wire logic req_i,
  output logic warm_o
);
  logic [7:0] cnt_reg;

  // Reload on every request, count down otherwise.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cnt_reg <= 8'h00;
      warm_o <= 1'b0;
    end else if (ce_i) begin
      if (req_i) begin
        cnt_reg <= 8'(CYCLES);
        warm_o <= 1'b1;
      end else if (cnt_reg > 8'h01) begin
        cnt_reg <= cnt_reg - 8'h01;
      end else begin
        cnt_reg <= 8'h00;
        warm_o <= 1'b0;
      end
    end
  end
endmodule

// [verilog/rbh_reset_ctrl.sv]
/*
 Reset and boot handshake controller: hardware reset, boot handshake on the
 attention output, masked warm reset sources, per-module software resets,
 and an AHB-Lite register slave with a level interrupt.
 Assumes one 250 MHz clock; nrst_i is the synchronised hardware reset.
*/
// Operation
// - Hardware reset low keeps modules disabled and registers at defaults.
// - Boot sequence starts only after hardware reset goes high.
// - Attention output goes low when ready for download.
// - Attention output goes high when boot completes.
// - After hardware reset the reference clock is the clock source.
// - Four masked triggers combine into warm reset of core and peripherals.
// - Warm reset leaves core configuration and RAM untouched.
// - Debug reset pin low causes warm reset unless its mask is set.
// - Watchdog resets only if enabled and unmasked; enable off at reset.
// - PLL unlock causes warm reset unless its mask is set.
// - Wake interrupt starts wake logic; resets only if wake enable set.
// - Each peripheral has its own software reset field.
// - Field at zero holds peripheral in reset; one lets it run.
// - Wake warm reset restarts at vector chosen by select field.
// - Test port logic ignores warm and software reset; own reset only.
`timescale 1ns/10ps
`include "rbh_defines.svh"
module rbh_reset_ctrl
  import rbh_pkg::*;
#(
  parameter int N_PERIPH = 8,
  parameter int SELFTEST_CYCLES = 16
) (
  // Clock, reset and clock enable.
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Warm reset sources.
  input wire logic debug_warm_reset_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic pll_unlock_i,
  input wire logic wake_interrupt_n_i,
  // Boot progress from the boot code.
  input wire logic boot_selftest_done_i,
  input wire logic boot_download_done_i,
  // Fuse or download clock selection.
  input wire logic clk_sel_load_i,
  input wire logic clk_sel_pll_i,
  // Test port reset.
  input wire logic test_reset_n_i,
  // Outputs.
  output logic attention_n_o,
  output logic warm_reset_o,
  output logic core_reset_o,
  output logic [N_PERIPH-1:0] periph_reset_n_o,
  output logic clk_sel_pll_o,
  output logic alt_vector_o,
  output logic test_port_reset_n_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [`RBH_CTRL_WIDTH-1:0] ctrl_reg;
  logic [N_PERIPH-1:0] softrst_reg;
  logic [`RBH_INT_WIDTH-1:0] int_stat_reg;
  logic [`RBH_INT_WIDTH-1:0] int_en_reg;
  logic [`RBH_INT_WIDTH-1:0] int_evt;
  logic [3:0] cause_reg;
  logic [3:0] trig;
  rbh_boot_t boot_reg;
  logic [7:0] st_cnt_reg;
  logic dbg_lvl;
  logic wdt_lvl;
  logic pll_lvl;
  logic wake_lvl;
  logic wake_prev_reg;
  logic wake_pend_reg;
  logic warm_req;
  logic warm;
  logic warm_prev_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic boot_ready_pulse;
  logic boot_done_pulse;
  logic ahb_go;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for asynchronous sources.
  rbh_sync3 #(.RESET_VAL(1'b1)) u_sync_dbg (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .pin_i(debug_warm_reset_n_i),
    .level_o(dbg_lvl)
  );
  rbh_sync3 #(.RESET_VAL(1'b0)) u_sync_wdt (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .pin_i(watchdog_timeout_i),
    .level_o(wdt_lvl)
  );
  rbh_sync3 #(.RESET_VAL(1'b0)) u_sync_pll (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .pin_i(pll_unlock_i),
    .level_o(pll_lvl)
  );
  rbh_sync3 #(.RESET_VAL(1'b1)) u_sync_wake (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .pin_i(wake_interrupt_n_i),
    .level_o(wake_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up logic: a falling wake interrupt arms a pending wake event.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      wake_prev_reg <= 1'b1;
      wake_pend_reg <= 1'b0;
    end else if (ce_i) begin
      wake_prev_reg <= wake_lvl;
      wake_pend_reg <= wake_prev_reg && !wake_lvl;
    end
  end

  // Masked trigger combination.
  assign trig[0] = !dbg_lvl && !ctrl_reg[`RBH_CTRL_DBG_MSK];
  assign trig[1] = wdt_lvl && ctrl_reg[`RBH_CTRL_WDT_ENA]
                   && !ctrl_reg[`RBH_CTRL_WATCHDOG_RESET_MASK];
  assign trig[2] = pll_lvl && !ctrl_reg[`RBH_CTRL_PLL_UNLOCK_MASK];
  assign trig[3] = wake_pend_reg && ctrl_reg[`RBH_CTRL_WKUP_ENA];
  assign warm_req = |trig;

  rbh_warm_stretch u_stretch (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .req_i(warm_req),
    .warm_o(warm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Boot sequencer: held in reset, self-test, ready for download, running.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      boot_reg <= RBH_ST_HELD;
      st_cnt_reg <= 8'h00;
    end else if (ce_i) begin
      if (warm) begin
        boot_reg <= RBH_ST_HELD;
        st_cnt_reg <= 8'h00;
      end else begin
        unique case (boot_reg)
          RBH_ST_HELD: begin
            boot_reg <= RBH_ST_SELFTEST;
          end
          RBH_ST_SELFTEST: begin
            if (st_cnt_reg != 8'(SELFTEST_CYCLES)) begin
              st_cnt_reg <= st_cnt_reg + 8'h01;
            end else if (boot_selftest_done_i) begin
              boot_reg <= RBH_ST_READY;
            end
          end
          RBH_ST_READY: begin
            if (boot_download_done_i) begin
              boot_reg <= RBH_ST_RUN;
            end
          end
          RBH_ST_RUN: begin
            boot_reg <= RBH_ST_RUN;
          end
          default: begin
            boot_reg <= RBH_ST_HELD;
          end
        endcase
      end
    end
  end

  assign boot_ready_pulse = ce_i && !warm && (boot_reg == RBH_ST_SELFTEST)
                            && (st_cnt_reg == 8'(SELFTEST_CYCLES))
                            && boot_selftest_done_i;
  assign boot_done_pulse = ce_i && !warm && (boot_reg == RBH_ST_READY)
                           && boot_download_done_i;

  // Attention output follows the boot state.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      attention_n_o <= 1'b1;
    end else if (ce_i) begin
      if (boot_ready_pulse) begin
        attention_n_o <= 1'b0;
      end else if (boot_done_pulse || warm) begin
        attention_n_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset outputs to core and peripherals.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      warm_reset_o <= 1'b0;
      core_reset_o <= 1'b1;
      warm_prev_reg <= 1'b0;
    end else if (ce_i) begin
      warm_reset_o <= warm;
      core_reset_o <= warm || (boot_reg == RBH_ST_HELD);
      warm_prev_reg <= warm;
    end
  end

  // Per-peripheral reset: software field and warm reset, independent paths.
  genvar gi;
  generate
    for (gi = 0; gi < N_PERIPH; gi++) begin : g_periph
      always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
          periph_reset_n_o[gi] <= 1'b0;
        end else if (ce_i) begin
          periph_reset_n_o[gi] <= softrst_reg[gi] && !warm;
        end
      end
    end
  endgenerate

  // Test port reset follows only its own pin, never warm or soft reset.
  rbh_sync3 #(.RESET_VAL(1'b0)) u_sync_trst (
    .mclk_i(mclk_i),
    .nrst_i(1'b1),
    .ce_i(ce_i),
    .pin_i(test_reset_n_i),
    .level_o(test_port_reset_n_o)
  );

  // Clock source: reference clock after hardware reset until selected.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      clk_sel_pll_o <= 1'b0;
    end else if (ce_i && clk_sel_load_i) begin
      clk_sel_pll_o <= clk_sel_pll_i;
    end
  end

  // Restart vector latched on a wake-caused warm reset.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      alt_vector_o <= 1'b0;
    end else if (ce_i && trig[3]) begin
      alt_vector_o <= ctrl_reg[`RBH_CTRL_VECT_SEL];
    end else if (ce_i && warm_req) begin
      alt_vector_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY.
  assign ahb_go = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      wr_pend_reg <= ahb_go && hwrite_i;
      wr_addr_reg <= haddr_i;
      hrdata_o <= 32'h0000_0000;
      if (ahb_go && !hwrite_i) begin
        case (haddr_i)
          `RBH_OFS_CTRL: hrdata_o <= 32'(ctrl_reg);
          `RBH_OFS_STATUS: hrdata_o <= 32'(int_stat_reg);
          `RBH_OFS_INT_EN: hrdata_o <= 32'(int_en_reg);
          `RBH_OFS_SOFTRST: hrdata_o <= 32'(softrst_reg);
          `RBH_OFS_BOOT: hrdata_o <= {28'h0000000, boot_reg};
          `RBH_OFS_CAUSE: hrdata_o <= {28'h0000000, cause_reg};
          default: hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register: core configuration, untouched by warm reset.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      ctrl_reg <= `RBH_CTRL_RESET;
    end else if (ce_i && wr_pend_reg && wr_addr_reg == `RBH_OFS_CTRL) begin
      ctrl_reg <= hwdata_i[`RBH_CTRL_WIDTH-1:0];
    end
  end

  // Software reset fields, untouched by warm reset.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      softrst_reg <= N_PERIPH'(`RBH_SOFTRST_RESET);
    end else if (ce_i && wr_pend_reg
                 && wr_addr_reg == `RBH_OFS_SOFTRST) begin
      softrst_reg <= hwdata_i[N_PERIPH-1:0];
    end
  end

  // Latching cause of the last warm reset; a new trigger sets a bit.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cause_reg <= 4'h0;
    end else if (ce_i) begin
      if (warm_req && !warm) begin
        cause_reg <= trig;
      end else if (warm_req) begin
        cause_reg <= cause_reg | trig;
      end
    end
  end

  // Interrupt status: set wins over a clear in the same cycle.
  assign int_evt = {warm && !warm_prev_reg, boot_done_pulse,
                    boot_ready_pulse};

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      int_stat_reg <= '0;
      int_en_reg <= '0;
    end else if (ce_i) begin
      if (wr_pend_reg && wr_addr_reg == `RBH_OFS_INT_CLR) begin
        int_stat_reg <= (int_stat_reg & ~hwdata_i[`RBH_INT_WIDTH-1:0])
                        | int_evt;
      end else begin
        int_stat_reg <= int_stat_reg | int_evt;
      end
      if (wr_pend_reg && wr_addr_reg == `RBH_OFS_INT_EN) begin
        int_en_reg <= hwdata_i[`RBH_INT_WIDTH-1:0];
      end
    end
  end

  // Level interrupt output.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(int_stat_reg & int_en_reg);
    end
  end
endmodule

// [testbench/rbh_chk.sv]
/* Port checker for the reset and boot handshake controller.
   Assumes it is bound to rbh_reset_ctrl by the bench top file. */
`timescale 1ns/10ps
module rbh_chk #(
  parameter int N_PERIPH = 8
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Design inputs.
  input wire logic debug_warm_reset_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic pll_unlock_i,
  input wire logic wake_interrupt_n_i,
  input wire logic boot_selftest_done_i,
  input wire logic boot_download_done_i,
  input wire logic clk_sel_load_i,
  input wire logic clk_sel_pll_i,
  input wire logic test_reset_n_i,
  // Design outputs.
  input wire logic attention_n_o,
  input wire logic warm_reset_o,
  input wire logic core_reset_o,
  input wire logic [N_PERIPH-1:0] periph_reset_n_o,
  input wire logic clk_sel_pll_o,
  input wire logic alt_vector_o,
  input wire logic test_port_reset_n_o
);
  logic [4:0] quiet_reg;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////
  // Counts cycles since any warm trigger was last active.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || !debug_warm_reset_n_i || watchdog_timeout_i ||
        pll_unlock_i || !wake_interrupt_n_i) begin
      quiet_reg <= 5'h00;
    end else if (quiet_reg != 5'h1F) begin
      quiet_reg <= quiet_reg + 5'h01;
    end
  end
  // Eight warm cycles in a row.
  sequence warm_hold8;
    warm_reset_o [*8];
  endsequence
  hw_defaults_a: assert property (
    !$past(nrst_i) |-> attention_n_o && core_reset_o && !clk_sel_pll_o &&
    !alt_vector_o && ~|periph_reset_n_o)
    else $error("outputs not at reset values");
  boot_wait_a: assert property (
    $rose(nrst_i) |-> attention_n_o [*8])
    else $error("attention fell too early");
  attn_ready_a: assert property (
    $fell(attention_n_o) |-> $past(boot_selftest_done_i) && !warm_reset_o)
    else $error("attention fell before self test");
  attn_done_a: assert property (
    !attention_n_o && boot_download_done_i |-> ##[1:3] attention_n_o)
    else $error("attention held after download");
  warm_effect_a: assert property (
    warm_reset_o |-> core_reset_o && attention_n_o && ~|periph_reset_n_o)
    else $error("warm reset not applied");
  warm_cause_a: assert property (
    $rose(warm_reset_o) |-> quiet_reg < 5'h0C)
    else $error("warm reset without trigger");
  warm_min_a: assert property (
    $rose(warm_reset_o) |-> warm_hold8 ##1 warm_hold8)
    else $error("warm reset too short");
  clk_src_a: assert property (
    $rose(clk_sel_pll_o) |-> $past(clk_sel_load_i && clk_sel_pll_i))
    else $error("clock source changed without load");
  alt_vec_a: assert property (
    $rose(alt_vector_o) |-> ##[0:2] warm_reset_o)
    else $error("vector select outside warm reset");
  test_port_a: assert property (
    $stable(test_reset_n_i) [*5] |-> test_port_reset_n_o == test_reset_n_i)
    else $error("test port reset off its pin");
endmodule

// [testbench/rbh_host_model.sv]
/* Host and debug probe on the far side of the controller.
   Assumes the bench requests probe resets through probe_req_i. */
`timescale 1ns/10ps
module rbh_host_model #(
  parameter int DL_DELAY = 24
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Requests and device status.
  input wire logic probe_req_i,
  input wire logic attention_n_i,
  // Lines into the device.
  output logic debug_warm_reset_n_o = 1'b1,
  output logic selftest_done_o = 1'b0,
  output logic download_done_o = 1'b0
);
  int wait_cnt = 0;
  ////////////////////////////////
  // Probe line follows requests; a slow host ends the download later.
  always @(posedge mclk_i) begin
    debug_warm_reset_n_o <= !probe_req_i;
    selftest_done_o <= nrst_i;
    download_done_o <= 1'b0;
    if (attention_n_i) begin
      wait_cnt <= 0;
    end else if (wait_cnt == DL_DELAY) begin
      download_done_o <= 1'b1;
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// [testbench/rbh_reset_ctrl_test.sv]
/* Self-checking bench for the reset and boot handshake controller.
   Assumes design, checker and host model are compiled first. */
`timescale 1ns/10ps
module rbh_reset_ctrl_test;
  // Bench-driven inputs.
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic watchdog_timeout_i = 1'b0;
  logic pll_unlock_i = 1'b0;
  logic wake_interrupt_n_i = 1'b1;
  logic clk_sel_load_i = 1'b0;
  logic clk_sel_pll_i = 1'b0;
  logic test_reset_n_i = 1'b1;
  logic probe_req = 1'b0;
  // Design outputs and model lines.
  logic debug_warm_reset_n_i, boot_selftest_done_i, boot_download_done_i;
  logic hreadyout_o, hresp_o, attention_n_o, warm_reset_o, core_reset_o;
  logic clk_sel_pll_o, alt_vector_o, test_port_reset_n_o, irq_o;
  logic [7:0] periph_reset_n_o;
  logic [31:0] hrdata_o;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  ////////////////////////////////
  rbh_reset_ctrl #(.N_PERIPH(8), .SELFTEST_CYCLES(16)) DUT (
    .mclk_i, .nrst_i, .ce_i, .hsel_i(1'b1), .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
    .hrdata_o, .hreadyout_o, .hresp_o, .debug_warm_reset_n_i,
    .watchdog_timeout_i, .pll_unlock_i, .wake_interrupt_n_i,
    .boot_selftest_done_i, .boot_download_done_i, .clk_sel_load_i,
    .clk_sel_pll_i, .test_reset_n_i, .attention_n_o, .warm_reset_o,
    .core_reset_o, .periph_reset_n_o, .clk_sel_pll_o, .alt_vector_o,
    .test_port_reset_n_o, .irq_o);
  rbh_host_model #(.DL_DELAY(24)) u_host (.mclk_i, .nrst_i,
    .probe_req_i(probe_req), .attention_n_i(attention_n_o),
    .debug_warm_reset_n_o(debug_warm_reset_n_i),
    .selftest_done_o(boot_selftest_done_i),
    .download_done_o(boot_download_done_i));
  // A 4 ns clock and a hang guard.
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end
  // Compares and counts.
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // One single AHB-Lite transfer, waiting on ready in both phases.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(what, x, exp);
  endtask
  // Waits, bounded, for attention (0) or warm reset (1) to reach v.
  task automatic wait_sig(input logic which, input logic v);
    int n;
    for (n = 0; n < 400 && (which ? warm_reset_o : attention_n_o) !== v;
         n++) @(posedge mclk_i);
    check("wait", which ? warm_reset_o : attention_n_o, v);
  endtask
  // Drives one warm trigger source on or off.
  task automatic pulse(input int src, input logic on);
    probe_req <= on && src == 0;
    watchdog_timeout_i <= on && src == 1;
    pll_unlock_i <= on && src == 2;
    wake_interrupt_n_i <= !(on && src == 3);
  endtask
  task automatic t_regs();
    check("attn", attention_n_o, 1'b1);
    check("clksel", clk_sel_pll_o, 1'b0);
    rd_chk("ctrl", 8'h00, 32'h0);
    rd_chk("softrst", 8'h10, 32'h0);
    rd_chk("hole", 8'h1C, 32'h0);
    check("hresp", hresp_o, 1'b0);
    check("periph", periph_reset_n_o, 8'h00);
    wr(8'h10, 32'hA5);
    repeat (2) @(posedge mclk_i);
    check("periph", periph_reset_n_o, 8'hA5);
  endtask
  task automatic t_boot();
    wait_sig(1'b0, 1'b0);
    rd_chk("boot", 8'h14, 32'h4);
    rd_chk("status", 8'h04, 32'h1);
    wait_sig(1'b0, 1'b1);
    rd_chk("boot", 8'h14, 32'h8);
  endtask
  // Each trigger blocked by mask or enable, then let through.
  task automatic t_warm();
    int src[9] = '{0, 0, 1, 1, 1, 2, 2, 3, 3};
    logic [5:0] ctl[9] = '{6'h01, 6'h00, 6'h00, 6'h12, 6'h10, 6'h04,
                           6'h00, 6'h00, 6'h28};
    logic [8:0] hit = 9'h152;
    logic [31:0] x;
    int n;
    for (int r = 0; r < 9; r++) begin
      wr(8'h00, {26'h0, ctl[r]});
      pulse(src[r], 1'b1);
      n = 0;
      for (int c = 0; c < 60; c++) begin
        @(posedge mclk_i);
        if (c == 12) pulse(src[r], 1'b0);
        if (warm_reset_o === 1'b1) n++;
      end
      check("warm", n != 0, hit[r]);
      if (hit[r]) begin
        rd_chk("ctrl", 8'h00, {26'h0, ctl[r]});
        rd_chk("softrst", 8'h10, 32'hA5);
        check("periph", periph_reset_n_o, 8'hA5);
        bus(1'b0, 8'h18, 32'h0, x);
        check("cause", x[src[r]], 1'b1);
        check("altvec", alt_vector_o, src[r] == 3);
      end
    end
  endtask
  task automatic irq_step(input logic [7:0] a, input logic [31:0] d,
                          input logic exp);
    wr(a, d);
    repeat (2) @(posedge mclk_i);
    check("irq", irq_o, exp);
  endtask
  task automatic t_trst();
    test_reset_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    check("tport", test_port_reset_n_o, 1'b0);
    test_reset_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    check("tport", test_port_reset_n_o, 1'b1);
  endtask
  // A write while the clock enable is low must leave the software reset field as it was.
  task automatic t_freeze();
    ce_i <= 1'b0;
    wr(8'h10, 32'h5A);
    repeat (2) @(posedge mclk_i);
    check("frozen", periph_reset_n_o, 8'hA5);
    ce_i <= 1'b1;
    rd_chk("softrst", 8'h10, 32'hA5);
  endtask
  // Clock choice loaded, then a second hardware reset mid-run.
  task automatic t_hwreset();
    clk_sel_load_i <= 1'b1;
    clk_sel_pll_i <= 1'b1;
    @(posedge mclk_i);
    clk_sel_load_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    check("clksel", clk_sel_pll_o, 1'b1);
    nrst_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    check("tport", test_port_reset_n_o, 1'b1);
    check("periph", periph_reset_n_o, 8'h00);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    check("clksel", clk_sel_pll_o, 1'b0);
    rd_chk("ctrl", 8'h00, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_boot();
    t_warm();
    irq_step(8'h0C, 32'h0, 1'b0);
    irq_step(8'h0C, 32'h4, 1'b1);
    irq_step(8'h08, 32'h4, 1'b0);
    t_trst();
    t_freeze();
    t_hwreset();
    tally_and_finish();
  end
endmodule
bind rbh_reset_ctrl rbh_chk #(.N_PERIPH(N_PERIPH)) u_chk (.mclk_i, .nrst_i,
  .debug_warm_reset_n_i, .watchdog_timeout_i, .pll_unlock_i,
  .wake_interrupt_n_i, .boot_selftest_done_i, .boot_download_done_i,
  .clk_sel_load_i, .clk_sel_pll_i, .test_reset_n_i, .attention_n_o,
  .warm_reset_o, .core_reset_o, .periph_reset_n_o, .clk_sel_pll_o,
  .alt_vector_o, .test_port_reset_n_o);
